// ### ivp_vector_place.v
/*
 Interrupt vector placement: control register over AXI4-Lite, timed unlock
 of the vector table select, interrupt hold-off and vector/reset bases.
 Assumes fuses and lock bits are static levels synchronous to core_clk and
 that the CPU reports which section it executes from and when an
 instruction retires.
*/
// Chosen here: the register addresses and the AXI4-Lite slave port.
// Overview of operation
// RULE1: Select zero puts vectors at flash start; one puts them at boot start.
// RULE2: Boot start, hence relocated base, follows boot size fuse; 4K gives 3800.
// RULE3: Unprogrammed reset fuse resets to zero while vectors sit at boot plus two.
// RULE4: Programmed reset fuse starts execution at the boot reset address.
// RULE5: Relocated vector address is normal table address plus boot start.
// RULE6: Software sets unlock, then within four cycles writes select with unlock zero.
// RULE7: Unlock clears by hardware four cycles after set or when select is written.
// RULE8: Interrupts blocked from unlock set until after the instruction after select write.
// RULE9: Without a select write, interrupts stay blocked four cycles then release.
// RULE10: Automatic blocking never touches the global interrupt enable flag.
// RULE11: Vectors in boot and app lock programmed block interrupts in application code.
// RULE12: Vectors in application and boot lock programmed block interrupts in boot code.
// RULE13: Eight bit control register resets zero; bits 4 to 2 read only.
// RULE14: A select write without an open unlock window leaves placement unchanged.
`timescale 1ns/1ps
`include "ivp_regs.vh"
module ivp_vector_place #(
   parameter ADDR_W = 4
) (
   input wire core_clk,
   input wire rst,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire boot_reset_fuse_n,
   input wire [1:0] boot_size_fuse,
   input wire app_section_lock_b_n,
   input wire boot_section_lock_b_n,
   input wire exec_in_boot,
   input wire insn_retire,
   output reg [15:0] vector_base,
   output reg [15:0] reset_address,
   output wire irq_block,
   output wire ext_irq_zero_enable,
   output wire ext_irq_one_enable,
   output wire ext_irq_two_enable,
   output wire vector_table_select
);
   reg [7:0] ctrl;
   reg [2:0] unlock_cnt;
   reg [2:0] hold_state;
   reg [ADDR_W-1:0] aw_addr;
   reg aw_full;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_full;
   reg [15:0] boot_start;
   wire do_write;
   wire ctrl_hit;
   wire lane0;
   wire [7:0] wr_byte;
   wire unlock_open;
   wire sel_write;
   wire lock_block;

   localparam HOLD_IDLE = 3'b001;
   localparam HOLD_WAIT = 3'b010;
   localparam HOLD_INSN = 3'b100;

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign ctrl_hit = (aw_addr == `IVP_CTRL_OFFSET);
   assign lane0 = w_strb[0];
   assign wr_byte = w_data[7:0];
   assign unlock_open = ctrl[`IVP_BIT_UNLOCK];
   // A control write with unlock clear while the window is open changes the select.
   assign sel_write = do_write && ctrl_hit && lane0 && unlock_open
      && !wr_byte[`IVP_BIT_UNLOCK]; // RULE6
   assign ext_irq_zero_enable = ctrl[`IVP_BIT_IRQ0];
   assign ext_irq_one_enable = ctrl[`IVP_BIT_IRQ1];
   assign ext_irq_two_enable = ctrl[`IVP_BIT_IRQ2];
   assign vector_table_select = ctrl[`IVP_BIT_SELECT];
   assign lock_block = (ctrl[`IVP_BIT_SELECT] && !app_section_lock_b_n && !exec_in_boot) // RULE11
      || (!ctrl[`IVP_BIT_SELECT] && !boot_section_lock_b_n && exec_in_boot); // RULE12
   // Block output only gates delivery; the global enable flag lives in the CPU.
   assign irq_block = unlock_open || (hold_state != HOLD_IDLE) || lock_block; // RULE8 RULE10

   always @* begin
      case (boot_size_fuse)
         2'b00: boot_start = `IVP_BOOT_4K; // RULE2
         2'b01: boot_start = `IVP_BOOT_2K;
         2'b10: boot_start = `IVP_BOOT_1K;
         default: boot_start = `IVP_BOOT_512;
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         vector_base <= 16'h0000;
         reset_address <= 16'h0000;
      end else begin
         vector_base <= ctrl[`IVP_BIT_SELECT] ? boot_start + `IVP_VEC_OFFSET
            : `IVP_VEC_OFFSET; // RULE1 RULE3 RULE5
         reset_address <= boot_reset_fuse_n ? 16'h0000 : boot_start; // RULE3 RULE4
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         aw_full <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IVP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (ctrl_hit || aw_addr == `IVP_STAT_OFFSET) ? `IVP_RESP_OKAY
               : `IVP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         ctrl <= `IVP_CTRL_RESET; // RULE13
         unlock_cnt <= 3'h0;
      end else begin
         if (do_write && ctrl_hit && lane0) begin
            ctrl[`IVP_BIT_IRQ1] <= wr_byte[`IVP_BIT_IRQ1];
            ctrl[`IVP_BIT_IRQ0] <= wr_byte[`IVP_BIT_IRQ0];
            ctrl[`IVP_BIT_IRQ2] <= wr_byte[`IVP_BIT_IRQ2];
         end
         if (sel_write) begin
            ctrl[`IVP_BIT_SELECT] <= wr_byte[`IVP_BIT_SELECT];
            ctrl[`IVP_BIT_UNLOCK] <= 1'b0; // RULE7
            unlock_cnt <= 3'h0;
         end else if (do_write && ctrl_hit && lane0 && wr_byte[`IVP_BIT_UNLOCK]) begin
            // Select is ignored in the unlock write itself.
            ctrl[`IVP_BIT_UNLOCK] <= 1'b1; // RULE14
            unlock_cnt <= `IVP_UNLOCK_CYCLES;
         end else if (unlock_open) begin
            if (unlock_cnt == 3'h1) begin
               ctrl[`IVP_BIT_UNLOCK] <= 1'b0; // RULE7 RULE9
            end
            unlock_cnt <= unlock_cnt - 3'h1;
         end
      end
   end

   // After the select write, hold interrupts until the following instruction retires.
   always @(posedge core_clk) begin
      if (rst) begin
         hold_state <= HOLD_IDLE;
      end else begin
         case (hold_state)
            HOLD_IDLE: if (sel_write) hold_state <= HOLD_WAIT; // RULE8
            HOLD_WAIT: if (insn_retire) hold_state <= HOLD_INSN;
            HOLD_INSN: if (insn_retire) hold_state <= HOLD_IDLE;
            default: hold_state <= HOLD_IDLE;
         endcase
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `IVP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `IVP_RESP_OKAY;
         if (s_axi_araddr == `IVP_CTRL_OFFSET) begin
            s_axi_rdata <= {24'h000000, ctrl & `IVP_CTRL_WMASK};
         end else if (s_axi_araddr == `IVP_STAT_OFFSET) begin
            s_axi_rdata <= {reset_address, vector_base};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IVP_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // ivp_vector_place

// ### ivp_regs.vh
/*
 Register offsets, field positions, reset values and timing counts for the
 interrupt vector placement block. Assumes inclusion by bare name.
*/
`ifndef IVP_REGS_VH
`define IVP_REGS_VH
`define IVP_CTRL_OFFSET 4'h0
`define IVP_STAT_OFFSET 4'h4
`define IVP_CTRL_RESET 8'h00
`define IVP_BIT_UNLOCK 0
`define IVP_BIT_SELECT 1
`define IVP_BIT_IRQ2 5
`define IVP_BIT_IRQ0 6
`define IVP_BIT_IRQ1 7
`define IVP_CTRL_WMASK 8'he3
`define IVP_UNLOCK_CYCLES 3'h4
`define IVP_VEC_OFFSET 16'h0002
`define IVP_BOOT_4K 16'h3800
`define IVP_BOOT_2K 16'h3c00
`define IVP_BOOT_1K 16'h3e00
`define IVP_BOOT_512 16'h3f00
`define IVP_RESP_OKAY 2'h0
`define IVP_RESP_SLVERR 2'h2
`endif

// ### ivp_asserts.sv
/* Port assertions for the vector placement block.
 Bound to every ivp_vector_place; one clock, synchronous reset. */
`timescale 1ns/1ps
module ivp_asserts (
   input wire core_clk,
   input wire rst,
   input wire [1:0] boot_size_fuse,
   input wire boot_reset_fuse_n,
   input wire app_section_lock_b_n,
   input wire boot_section_lock_b_n,
   input wire exec_in_boot,
   input wire [15:0] vector_base,
   input wire [15:0] reset_address,
   input wire irq_block,
   input wire vector_table_select
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire sel = vector_table_select;
   wire k4 = boot_size_fuse == 2'h0;
   wire nl = app_section_lock_b_n && boot_section_lock_b_n;
   property p_va; !$past(rst) && !$past(sel) |-> vector_base == 16'h0002; endproperty
   a_va: assert property (p_va) else $error("bad vector base");
   property p_vb; !$past(rst) && $past(sel && k4) |-> vector_base == 16'h3802; endproperty
   a_vb: assert property (p_vb) else $error("bad boot vector base");
   property p_rz; !$past(rst) && $past(boot_reset_fuse_n) |-> reset_address == 16'h0000; endproperty
   a_rz: assert property (p_rz) else $error("bad reset address");
   property p_rb; !$past(rst) && $past(!boot_reset_fuse_n && k4) |-> reset_address == 16'h3800; endproperty
   a_rb: assert property (p_rb) else $error("bad boot reset address");
   property p_la; sel && !app_section_lock_b_n && !exec_in_boot |-> irq_block; endproperty
   a_la: assert property (p_la) else $error("irq open in app code");
   property p_lb; !sel && !boot_section_lock_b_n && exec_in_boot |-> irq_block; endproperty
   a_lb: assert property (p_lb) else $error("irq open in boot code");
   property p_sc; $changed(sel) |-> $past(irq_block) && irq_block; endproperty
   a_sc: assert property (p_sc) else $error("select moved unguarded");
   property p_ho; $rose(irq_block) && nl |=> irq_block; endproperty
   a_ho: assert property (p_ho) else $error("hold-off too short");
endmodule // ivp_asserts
bind ivp_vector_place ivp_asserts ivp_asserts_i (.core_clk, .rst, .boot_size_fuse,
   .boot_reset_fuse_n, .app_section_lock_b_n, .boot_section_lock_b_n, .exec_in_boot,
   .vector_base, .reset_address, .irq_block, .vector_table_select);

// ### test_interrupt_vector_placement.sv
/* Bench for the vector placement block.
 Drives the register bus, fuses, locks and CPU status directly. */
`timescale 1ns/1ps
`include "ivp_regs.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
   $display("mismatch %0t %h %h", $time, (a), (b)); end end
module test_interrupt_vector_placement;
   logic core_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, boot_reset_fuse_n = 1, exec_in_boot = 0;
   logic app_section_lock_b_n = 1, boot_section_lock_b_n = 1, insn_retire = 0, ta, tw, tb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_block;
   logic ext_irq_zero_enable, ext_irq_one_enable, ext_irq_two_enable, vector_table_select;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [1:0] boot_size_fuse = 0, s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [15:0] vector_base, reset_address;
   logic [15:0] bs [4] = '{`IVP_BOOT_4K, `IVP_BOOT_2K, `IVP_BOOT_1K, `IVP_BOOT_512};
   int failures = 0, comparisons = 0;
   ivp_vector_place ivp_vector_place_i (.*);
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #20000 failures++;
      report_and_stop;
   end
   task report_and_stop;
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(negedge core_clk);
         ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = w ? s_axi_bvalid : s_axi_rvalid;
         {rr, rd} = w ? {s_axi_bresp, d} : {s_axi_rresp, s_axi_rdata};
         @(posedge core_clk);
         if (ta && w) s_axi_awvalid <= 0;
         if (ta && !w) s_axi_arvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end while (!tb);
      `CHK(rd, d)
      `CHK(rr, r)
   endtask
   task move(input logic sel);
      xfer(1, 4'h0, 32'h1, `IVP_RESP_OKAY);
      xfer(1, 4'h0, {30'h0, sel, 1'h0}, `IVP_RESP_OKAY);
      @(negedge core_clk);
      `CHK(irq_block, 1'h1)
      repeat (2) begin
         @(posedge core_clk) insn_retire <= 1;
         @(posedge core_clk) insn_retire <= 0;
      end
      @(negedge core_clk);
      `CHK(irq_block, 1'h0)
      @(posedge core_clk);
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      xfer(0, 4'h0, 32'h0, `IVP_RESP_OKAY);
      for (int j = 0; j < 8; j++) begin
         if (j == 4) move(1'h1);
         {boot_size_fuse, boot_reset_fuse_n} <= {j[1:0], j[0]};
         repeat (2) @(posedge core_clk);
         xfer(0, 4'h4, {j[0] ? 16'h0 : bs[j[1:0]], (j[2] ? bs[j[1:0]] : 16'h0) + `IVP_VEC_OFFSET},
            `IVP_RESP_OKAY);
      end
      app_section_lock_b_n <= 0;
      @(negedge core_clk);
      `CHK(irq_block, 1'h1)
      @(posedge core_clk);
      {app_section_lock_b_n, exec_in_boot} <= 2'h3;
      move(1'h0);
      boot_section_lock_b_n <= 0;
      @(negedge core_clk);
      `CHK(irq_block, 1'h1)
      @(posedge core_clk);
      boot_section_lock_b_n <= 1;
      xfer(1, 4'h0, 32'h1, `IVP_RESP_OKAY);
      repeat (3) @(negedge core_clk);
      `CHK(irq_block, 1'h1)
      @(negedge core_clk);
      `CHK(irq_block, 1'h0)
      @(posedge core_clk);
      xfer(1, 4'h0, 32'hfe, `IVP_RESP_OKAY);
      xfer(0, 4'h0, 32'he0, `IVP_RESP_OKAY);
      `CHK({ext_irq_one_enable, ext_irq_zero_enable, ext_irq_two_enable}, 3'h7)
      xfer(1, 4'h8, 32'h0, `IVP_RESP_SLVERR);
      xfer(0, 4'h8, 32'h0, `IVP_RESP_SLVERR);
      report_and_stop;
   end
endmodule // test_interrupt_vector_placement
